// ### hdl/root_entry_check.sv
`default_nettype none
`include "root_entry_regs.svh"
// Pure combinational evaluation of one fetched root-entry
module root_entry_check (
    input wire logic [127:0] entry,
    input wire logic [5:0] host_address_width,
    output logic present,
    output logic rsvd_bad,
    output logic [63:0] ctx_table_base
);
    logic [63:0] haw_mask; // Ones below host address width

    // Mask pointer above host address width, check reserved fields
    always_comb begin
        haw_mask = (64'h1 << host_address_width) - 64'h1;
        present = entry[`RE_PRESENT_BIT];
        ctx_table_base = 64'h0;
        ctx_table_base[`RE_CTP_MSB:`RE_CTP_LSB] = entry[`RE_CTP_MSB:`RE_CTP_LSB];
        ctx_table_base = ctx_table_base & haw_mask;
        // Reserved fields only matter for a present entry
        rsvd_bad = present && ((|entry[`RE_RSVD_HI_MSB:`RE_RSVD_HI_LSB])
                   || (|entry[`RE_RSVD_LO_MSB:`RE_RSVD_LO_LSB]));
    end
endmodule : root_entry_check
`default_nettype wire

// ### hdl/root_entry_decoder.sv
// Functional notes
// - Bit 0 clear blocks the DMA request
// - Present entry with clear reserved fields yields context table for request
// - Bits 63:12 give 4KB-aligned context table base
// - Reserved fields checked only when present
// - Pointer bits at and above host address width ignored
//
// The register offsets and the plain strobed port were chosen for this implementation.
`default_nettype none
`include "root_entry_regs.svh"
module root_entry_decoder (
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // DMA request in
    input wire logic req_valid,
    input wire root_entry_pkg::dma_req_t req,
    output logic req_ready,
    // Memory read for root-entry fetch
    output logic mem_rd,
    output logic [63:0] mem_addr,
    input wire logic mem_valid,
    input wire logic [127:0] mem_data,
    // Result
    output logic rsp_valid,
    output root_entry_pkg::decode_rsp_t rsp
);
    // Decode sequence, one request in flight
    // Cycle 0: request taken while ready high
    // Cycle 1: ready low, request held
    // Cycle 2: fetch strobe, fetch address out
    // Cycle 3 or later: whole entry returned
    // Next cycle: entry held for evaluation
    // Cycle after: result strobe, ready back high
    // Memory latency only stretches the wait
    // Answer ignored outside the wait state
    // Next request may meet the result strobe
    // Result fields held until the next result
    // Fetch address held until the next fetch
    // Request fields not sampled while busy
    // Tag returned unchanged with the result
    // No ordering between buses beyond arrival
    // One outstanding fetch at any time

    // Register side: root table base, address width
    // Status, pointer and count for software to read
    // Width 0 masks the whole pointer away
    // Width 63 keeps all but the top pointer bit
    // Width reset value matches the platform default

    // Register state
    logic [63:0] root_base_q, root_base_d; // Root table base
    logic [5:0] haw_q, haw_d; // Host address width
    logic [31:0] rdata_q, rdata_d; // Read data pipeline
    logic [31:0] count_q, count_d; // Blocked request count
    logic [1:0] last_fault_q, last_fault_d; // Last fault code
    logic [63:0] last_ctp_q, last_ctp_d; // Last resolved pointer

    // Decode state, one set for the request in flight
    // Not software visible, except through the
    // status, pointer and count words
    // Decoder state
    root_entry_pkg::dec_state_t state_q, state_d;
    root_entry_pkg::dma_req_t cur_q, cur_d; // Captured request
    logic mem_rd_q, mem_rd_d; // Fetch strobe
    logic [63:0] mem_addr_q, mem_addr_d; // Fetch address
    logic [127:0] entry_q, entry_d; // Fetched entry
    logic rsp_valid_q, rsp_valid_d; // Result strobe
    root_entry_pkg::decode_rsp_t rsp_q, rsp_d; // Result
    logic ready_q, ready_d; // Accept flag

    // Evaluation of the fetched entry
    // Valid while in the done state
    // Ignored in every other state
    logic ent_present; // Present flag
    logic ent_rsvd_bad; // Reserved bits set in a present entry
    logic [63:0] ent_ctp; // Masked table base

    // Entry evaluation, purely combinational
    // Fed from the registered entry only
    // Width taken live from its register
    // Width change applies to the next result
    // Pointer bits at and above the width read zero
    // Reserved bits judged only for a present entry
    // Low twelve pointer bits always zero
    // Outputs used only in the done state
    root_entry_check u_check (
        .entry(entry_q),
        .host_address_width(haw_q),
        .present(ent_present),
        .rsvd_bad(ent_rsvd_bad),
        .ctx_table_base(ent_ctp)
    );

    // Entry registered before evaluation
    // Wide reductions kept off the return path
    // Present flag tested first
    // Cleared flag blocks whatever else is set
    // Stray data in an absent entry never faults
    // No pointer leaks from an absent entry
    // Reserved bits in a present entry block too
    // Malformed entry never trusted with a pointer
    // Blocked results carry a zero table base
    // Good results update the last pointer word
    // Every blocked result bumps the count
    // Count wraps silently at its full width
    // Fault code kept for the status word
    // Fetch address from the base at fetch time
    // Base change mid-request affects that fetch
    // Strobes default low, one cycle each
    // Unknown state falls back to idle and ready

    // Next-state logic of the decode sequence
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        mem_rd_d = 1'b0;
        mem_addr_d = mem_addr_q;
        entry_d = entry_q;
        rsp_valid_d = 1'b0;
        rsp_d = rsp_q;
        ready_d = ready_q;
        count_d = count_q;
        last_fault_d = last_fault_q;
        last_ctp_d = last_ctp_q;
        case (state_q)
            root_entry_pkg::ST_IDLE: begin
                // Take a request while ready
                if (req_valid && ready_q) begin
                    cur_d = req;
                    // Ready low until the result goes out
                    ready_d = 1'b0;
                    state_d = root_entry_pkg::ST_FETCH;
                end
            end
            root_entry_pkg::ST_FETCH: begin
                // Bus number indexes 16-byte entries
                mem_rd_d = 1'b1;
                mem_addr_d = root_base_q + (64'(cur_q.bus) << `RE_ENTRY_SHIFT);
                state_d = root_entry_pkg::ST_WAIT;
            end
            root_entry_pkg::ST_WAIT: begin
                // Wait for the whole 128-bit word
                // Data lines may toggle meanwhile
                if (mem_valid) begin
                    entry_d = mem_data;
                    state_d = root_entry_pkg::ST_DONE;
                end
            end
            root_entry_pkg::ST_DONE: begin
                rsp_valid_d = 1'b1;
                rsp_d.tag = cur_q.tag;
                if (!ent_present) begin
                    // Not present: block, fields ignored
                    rsp_d.blocked = 1'b1;
                    rsp_d.fault = `FAULT_NOT_PRESENT;
                    rsp_d.ctx_table_base = 64'h0;
                end else if (ent_rsvd_bad) begin
                    // Present but reserved bits set
                    rsp_d.blocked = 1'b1;
                    rsp_d.fault = `FAULT_RESERVED;
                    rsp_d.ctx_table_base = 64'h0;
                end else begin
                    // Present: hand on the context table
                    rsp_d.blocked = 1'b0;
                    rsp_d.fault = `FAULT_NONE;
                    rsp_d.ctx_table_base = ent_ctp;
                    last_ctp_d = ent_ctp;
                end
                // Count every blocked result
                if (!ent_present || ent_rsvd_bad) begin
                    count_d = count_q + 32'h1;
                end
                // Fault code for the status word
                last_fault_d = !ent_present ? `FAULT_NOT_PRESENT :
                               (ent_rsvd_bad ? `FAULT_RESERVED : `FAULT_NONE);
                ready_d = 1'b1;
                state_d = root_entry_pkg::ST_IDLE;
            end
            default: begin
                state_d = root_entry_pkg::ST_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    // Register map, 32-bit words
    // Root table base low, bits 11:0 forced zero
    // Root table base high, taken as written
    // Host address width, six bits used
    // Status: last fault, busy, ready
    // Last good table pointer, low word
    // Last good table pointer, high word
    // Count of blocked requests
    // Status, pointer and count read only
    // Writes to read-only words dropped
    // Unmapped writes dropped
    // Unmapped reads return zero
    // Read data one cycle after the strobe
    // Read data zero in every other cycle
    // Width change applies to the next result
    // Base change lands on the next fetch
    // Base rewritten by software only when idle

    // Next values of the register port
    always_comb begin
        root_base_d = root_base_q;
        haw_d = haw_q;
        rdata_d = 32'h0;
        if (reg_wr) begin
            case (reg_addr)
                // Root table base, 4KB aligned
                `REG_ROOT_BASE_LO: root_base_d[31:0] = {reg_wdata[31:12], 12'h000};
                `REG_ROOT_BASE_HI: root_base_d[63:32] = reg_wdata;
                // Upper bits of the width word ignored
                `REG_HAW: haw_d = reg_wdata[5:0];
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `REG_ROOT_BASE_LO: rdata_d = root_base_q[31:0];
                `REG_ROOT_BASE_HI: rdata_d = root_base_q[63:32];
                `REG_HAW: rdata_d = {26'h0, haw_q};
                // Busy, ready and last fault
                `REG_STATUS: rdata_d = {28'h0, last_fault_q, ~ready_q, ready_q};
                `REG_CTP_LO: rdata_d = last_ctp_q[31:0];
                `REG_CTP_HI: rdata_d = last_ctp_q[63:32];
                `REG_COUNT: rdata_d = count_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Decode reset: idle and ready
    // No fetch or result strobe out of reset
    // Count, fault and last pointer cleared
    // Entry cleared, reads as absent
    // Asynchronous clear, synchronous release
    // First request allowed at the first edge
    // Entry register written only on an answer
    // Current request written only on a take
    // Decode state registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= root_entry_pkg::ST_IDLE;
            cur_q <= '0;
            mem_rd_q <= 1'b0;
            mem_addr_q <= 64'h0;
            entry_q <= 128'h0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            ready_q <= 1'b1;
            count_q <= 32'h0;
            last_fault_q <= `FAULT_NONE;
            last_ctp_q <= 64'h0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            mem_rd_q <= mem_rd_d;
            mem_addr_q <= mem_addr_d;
            entry_q <= entry_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_q <= rsp_d;
            ready_q <= ready_d;
            count_q <= count_d;
            last_fault_q <= last_fault_d;
            last_ctp_q <= last_ctp_d;
        end
    end

    // Register port state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Base cleared, width at its default
            root_base_q <= 64'h0;
            haw_q <= `HOST_ADDRESS_WIDTH_DEF;
            rdata_q <= 32'h0;
        end else begin
            // Capture next register values
            root_base_q <= root_base_d;
            haw_q <= haw_d;
            rdata_q <= rdata_d;
        end
    end

    // Every output taken straight from a flop
    // No combinational path from input to output
    // Costs one cycle on each handshake
    // Read data zero outside its one cycle
    // Ready doubles as the idle indication
    // Fetch strobe one cycle per request
    // Result strobe one cycle per request
    // Result and address held between strobes
    // Outputs straight from flops
    assign reg_rdata = rdata_q;
    assign req_ready = ready_q;
    assign mem_rd = mem_rd_q;
    assign mem_addr = mem_addr_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp = rsp_q;

endmodule : root_entry_decoder
`default_nettype wire

// ### hdl/root_entry_pkg.sv
`default_nettype none
package root_entry_pkg;

    // Request from the remapping pipeline
    typedef struct packed {
        logic [7:0] bus;
        logic [15:0] tag;
    } dma_req_t;

    // Decode result toward the context-entry stage
    typedef struct packed {
        logic [15:0] tag;
        logic blocked;
        logic [1:0] fault;
        logic [63:0] ctx_table_base;
    } decode_rsp_t;

    // Decoder states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_WAIT = 4'h4,
        ST_DONE = 4'h8
    } dec_state_t;

endpackage : root_entry_pkg
`default_nettype wire

// ### hdl/root_entry_regs.svh
`ifndef ROOT_ENTRY_REGS_SVH
`define ROOT_ENTRY_REGS_SVH

// Root-entry field layout
`define RE_PRESENT_BIT 0
`define RE_RSVD_LO_MSB 11
`define RE_RSVD_LO_LSB 1
`define RE_CTP_MSB 63
`define RE_CTP_LSB 12
`define RE_RSVD_HI_MSB 127
`define RE_RSVD_HI_LSB 64
// Entry size in bytes as a shift (16 bytes)
`define RE_ENTRY_SHIFT 4
// Platform host address width, default value
`define HOST_ADDRESS_WIDTH_DEF 6'h27
// Fault codes
`define FAULT_NONE 2'h0
`define FAULT_NOT_PRESENT 2'h1
`define FAULT_RESERVED 2'h2

// Register map
`define REG_ROOT_BASE_LO 8'h00
`define REG_ROOT_BASE_HI 8'h04
`define REG_HAW 8'h08
`define REG_STATUS 8'h0C
`define REG_CTP_LO 8'h10
`define REG_CTP_HI 8'h14
`define REG_COUNT 8'h18

`endif

// ### test/root_entry_decoder_asserts.sv
`default_nettype none
module root_entry_decoder_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic req_valid,
    input wire root_entry_pkg::dma_req_t req,
    input wire logic req_ready,
    input wire logic mem_rd,
    input wire logic [63:0] mem_addr,
    input wire logic mem_valid,
    input wire logic [127:0] mem_data,
    input wire logic rsp_valid,
    input wire root_entry_pkg::decode_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic good; // Clean present entry answered
    logic rsvd_set; // Present entry with reserved bits set
    logic [127:0] ent_q; // Last answered entry
    logic [5:0] haw_q; // Address width as last written
    logic [63:0] base_exp; // Table base the rules call for
    assign good = mem_valid && mem_data[0] && ~|mem_data[127:64] && ~|mem_data[11:1];
    assign rsvd_set = mem_valid && mem_data[0] && (|mem_data[127:64] || |mem_data[11:1]);
    // Pointer bits at and above the width read as zero
    assign base_exp = {ent_q[63:12], 12'h000} & ~(64'hFFFF_FFFF_FFFF_FFFF << haw_q);
    // Hold the entry and the width for the result checks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ent_q <= '0;
            haw_q <= 6'h27;
        end else begin
            if (mem_valid) begin
                ent_q <= mem_data;
            end
            if (reg_wr && reg_addr == 8'h08) begin
                haw_q <= reg_wdata[5:0];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_TAKE: assert property (req_valid && req_ready |=> !req_ready)
        else $error("ready stayed high after take");
    AST_ADDR: assert property (req_valid && req_ready |-> ##2 mem_rd && mem_addr[11:0] == {$past(req.bus, 2), 4'h0})
        else $error("fetch address not bus times 16");
    AST_ABSENT: assert property (mem_valid && !mem_data[0] |-> ##2 rsp_valid && rsp.blocked && rsp.fault == 2'h1)
        else $error("absent entry not blocked");
    AST_PRESENT: assert property (good |-> ##2 rsp_valid && !rsp.blocked && rsp.fault == 2'h0)
        else $error("present entry blocked");
    AST_BASE: assert property (good |-> ##2 rsp.ctx_table_base == base_exp)
        else $error("table base wrong");
    AST_RSVD: assert property (rsvd_set |-> ##2 rsp_valid && rsp.blocked && rsp.fault == 2'h2)
        else $error("reserved bits not flagged");
    AST_READY: assert property (rsp_valid |-> req_ready && !$past(req_ready))
        else $error("ready not returned with result");
    AST_PULSE: assert property (rsp_valid |=> !rsp_valid)
        else $error("result longer than one cycle");
endmodule : root_entry_decoder_asserts
bind root_entry_decoder root_entry_decoder_asserts u_chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .req_valid, .req, .req_ready, .mem_rd, .mem_addr, .mem_valid, .mem_data, .rsp_valid, .rsp);
`default_nettype wire

// ### test/root_table_mem.sv
`default_nettype none
module root_table_mem (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mem_rd,
    input wire logic [63:0] mem_addr,
    input wire logic [7:0] lat,
    output logic mem_valid,
    output logic [127:0] mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] tbl [256]; // One root-entry per bus, 16 bytes apart
    logic [7:0] wait_q; // Remaining answer delay
    logic [7:0] idx_q; // Bus of the pending fetch
    logic busy_q; // Fetch pending
    // Answer each fetch lat+2 cycles after its strobe; data lines toggle when idle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            mem_valid <= 1'b0;
            mem_data <= '1;
        end else begin
            mem_valid <= 1'b0;
            mem_data <= ~mem_data;
            if (mem_rd) begin
                busy_q <= 1'b1;
                wait_q <= lat;
                idx_q <= mem_addr[11:4];
            end else if (busy_q && wait_q != 8'h00) begin
                wait_q <= wait_q - 8'h01;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                mem_valid <= 1'b1;
                mem_data <= tbl[idx_q];
            end
        end
    end
endmodule : root_table_mem
`default_nettype wire

// ### test/tb_dma_remap_root_entry_decode.sv
`default_nettype none
module tb_dma_remap_root_entry_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, reg_wr, reg_rd, req_valid, req_ready, mem_rd, mem_valid, rsp_valid;
    logic [7:0] reg_addr, lat;
    logic [31:0] reg_wdata, reg_rdata;
    logic [63:0] mem_addr;
    logic [127:0] mem_data;
    root_entry_pkg::dma_req_t req;
    root_entry_pkg::decode_rsp_t rsp;
    int fails = 0;
    int compares = 0;
    root_entry_decoder DUT (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req,
        .req_ready, .mem_rd, .mem_addr, .mem_valid, .mem_data, .rsp_valid, .rsp);
    root_table_mem u_mem (.clk, .nrst, .mem_rd, .mem_addr, .lat, .mem_valid, .mem_data);
    // Compare and count
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Register access, one-cycle strobes
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : reg_read
    // One request through a table entry
    task automatic run(input logic [7:0] bus, input logic [127:0] ent, input logic [7:0] l, input logic [1:0] flt,
        input logic [63:0] base);
        int n;
        u_mem.tbl[bus] = ent;
        lat <= l;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{bus: bus, tag: {8'hA5, bus}};
        @(posedge clk);
        req_valid <= 1'b0;
        for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(negedge clk);
        check("rsp_valid", rsp_valid, 64'h1);
        check("tag", rsp.tag, {8'hA5, bus});
        check("blocked", rsp.blocked, flt != 2'h0);
        check("fault", rsp.fault, flt);
        if (flt != 2'h2) check("base", rsp.ctx_table_base, base);
        check("mem_addr", mem_addr, 64'h1000 + {bus, 4'h0});
        @(posedge clk);
    endtask : run
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        wrap_up;
    end
    // Test sequence
    initial begin
        logic [31:0] d;
        {nrst, reg_wr, reg_rd, req_valid, reg_addr, reg_wdata, lat, req} = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        reg_read(8'h08, d);
        check("haw", d, 64'h27);
        reg_write(8'h00, 32'h0000_1ABC);
        reg_read(8'h00, d);
        check("root_lo", d, 64'h1000);
        reg_read(8'h40, d);
        check("unmapped", d, 64'h0);
        $display("registers done");
        run(8'h03, 128'hFFFF_0000_0000_0000_DEAD_BEEF_0000_0FFE, 8'h00, 2'h1, 64'h0);
        run(8'hFF, 128'hFFFF_FF12_3456_7001, 8'h06, 2'h0, 64'h0000_0012_3456_7000);
        run(8'h00, 128'h1_0000_0000_0000_5001, 8'h00, 2'h2, 64'h0);
        run(8'h80, 128'h9801, 8'h02, 2'h2, 64'h0);
        run(8'h01, 128'hA001, 8'h00, 2'h0, 64'hA000);
        reg_write(8'h08, 32'h0000_0020);
        run(8'h02, 128'hF1_2345_6001, 8'h01, 2'h0, 64'h2345_6000);
        $display("decode done");
        reg_read(8'h10, d);
        check("ctp_lo", d, 64'h2345_6000);
        reg_read(8'h14, d);
        check("ctp_hi", d, 64'h0);
        reg_read(8'h0C, d);
        check("status", d, 64'h1);
        reg_read(8'h04, d);
        check("root_hi", d, 64'h0);
        reg_read(8'h18, d);
        check("count", d, 64'h3);
        $display("status done");
        wrap_up;
    end
endmodule : tb_dma_remap_root_entry_decode
`default_nettype wire
